/* hw/cbcs_pkg.sv */
//==========================================================
// Notes on behaviour
// RULE1: Interrupt stacks flags at SP-6, dummy read SP-7.
// RULE2: Vector high from FFFA, low FFFB, load PC.
// RULE3: Relative branch: opcode, offset, dummy FFFF read.
// RULE4: Subroutine branch: six cycles, fourth reads target opcode.
// RULE5: Subroutine writes return low at SP, high SP-1.
// RULE6: Subroutine leaves stack pointer lowered by two.
//==========================================================
package cbcs_pkg;
   localparam logic [15:0] VEC_HI_ADDR = 16'hfffa;
   localparam logic [15:0] VEC_LO_ADDR = 16'hfffb;
   localparam logic [15:0] IDLE_ADDR = 16'hffff;
   localparam logic [15:0] FLAGS_OFS = 16'h0006;
   localparam logic [15:0] DUMMY_OFS = 16'h0007;
   localparam logic [15:0] SP_RESET = 16'h0000;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [7:0] BR_CYCLES = 8'h03;
   localparam logic [7:0] SUB_CYCLES = 8'h06;

   typedef enum logic [1:0] {
      CBCS_OP_NONE = 2'h0,
      CBCS_OP_SWI = 2'h1,
      CBCS_OP_BRANCH = 2'h2,
      CBCS_OP_SUB = 2'h3
   } cbcs_op_t;

   // Gray codes along the interrupt and subroutine sequences, from idle to their last state.
   typedef enum logic [3:0] {
      CBCS_IDLE = 4'h0,
      CBCS_SWI_CC = 4'h1,
      CBCS_SWI_DUM = 4'h3,
      CBCS_SWI_VH = 4'h2,
      CBCS_SWI_VL = 4'h6,
      CBCS_BR_OFS = 4'h7,
      CBCS_BR_DUM = 4'h5,
      CBCS_SB_OFS = 4'h4,
      CBCS_SB_DUM = 4'hc,
      CBCS_SB_TGT = 4'hd,
      CBCS_SB_WLO = 4'hf,
      CBCS_SB_WHI = 4'he
   } cbcs_state_t;
endpackage

/* hw/cbcs_sequencer.sv */
module cbcs_sequencer (
   input wire logic clk,
   input wire logic nrst,
   input wire logic start,
   input wire cbcs_pkg::cbcs_op_t op,
   input wire logic takeBranch,
   input wire logic [7:0] flags,
   input wire logic [7:0] dataIn,
   output logic [15:0] addr_r,
   output logic rdWr_r,
   output logic [7:0] dataOut_r,
   output logic [15:0] pc_r,
   output logic [15:0] sp_r,
   output logic busy_r
);
   import cbcs_pkg::*;

   cbcs_state_t state_r, state_nxt;
   logic [7:0] ofs_r;
   logic [7:0] vecHi_r;
   logic [15:0] ret_r;
   logic [15:0] target;
   logic [15:0] base;

   // Offset is relative to the address after the offset byte.
   assign base = pc_r + 16'h0002;

   cbcs_target_calc u_calc (
      .base(base),
      .offset(ofs_r),
      .target(target)
   );

   //==========================================================
   // Next state
   //==========================================================
   wire isIdle = (state_r == CBCS_IDLE);

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         CBCS_IDLE: begin
            if (start && op == CBCS_OP_SWI) state_nxt = CBCS_SWI_CC;
            else if (start && op == CBCS_OP_BRANCH) state_nxt = CBCS_BR_OFS;
            else if (start && op == CBCS_OP_SUB) state_nxt = CBCS_SB_OFS;
         end
         CBCS_SWI_CC: state_nxt = CBCS_SWI_DUM;
         CBCS_SWI_DUM: state_nxt = CBCS_SWI_VH;
         CBCS_SWI_VH: state_nxt = CBCS_SWI_VL;
         CBCS_SWI_VL: state_nxt = CBCS_IDLE;
         CBCS_BR_OFS: state_nxt = CBCS_BR_DUM;
         CBCS_BR_DUM: state_nxt = CBCS_IDLE;
         CBCS_SB_OFS: state_nxt = CBCS_SB_DUM;
         CBCS_SB_DUM: state_nxt = CBCS_SB_TGT;
         CBCS_SB_TGT: state_nxt = CBCS_SB_WLO;
         CBCS_SB_WLO: state_nxt = CBCS_SB_WHI;
         CBCS_SB_WHI: state_nxt = CBCS_IDLE;
         default: state_nxt = CBCS_IDLE;
      endcase
   end

   //==========================================================
   // Bus drive for the coming cycle
   //==========================================================
   logic [15:0] addrNxt;
   logic rdWrNxt;
   logic [7:0] dataNxt;

   always_comb begin
      addrNxt = IDLE_ADDR;
      rdWrNxt = 1'b1;
      dataNxt = 8'h00;
      unique case (state_nxt)
         // RULE1: flags stacked at SP-6
         CBCS_SWI_CC: begin
            addrNxt = sp_r - FLAGS_OFS;
            rdWrNxt = 1'b0;
            dataNxt = flags;
         end
         // RULE1: dummy read SP-7
         CBCS_SWI_DUM: addrNxt = sp_r - DUMMY_OFS;
         // RULE2: vector fetch addresses
         CBCS_SWI_VH: addrNxt = VEC_HI_ADDR;
         CBCS_SWI_VL: addrNxt = VEC_LO_ADDR;
         // RULE3: offset at opcode plus one
         CBCS_BR_OFS, CBCS_SB_OFS: addrNxt = pc_r + 16'h0001;
         // RULE3: dummy cycle on FFFF
         CBCS_BR_DUM, CBCS_SB_DUM: addrNxt = IDLE_ADDR;
         // RULE4: fourth cycle reads target opcode
         CBCS_SB_TGT: addrNxt = target;
         // RULE5: return address low then high
         CBCS_SB_WLO: begin
            addrNxt = sp_r;
            rdWrNxt = 1'b0;
            dataNxt = ret_r[7:0];
         end
         CBCS_SB_WHI: begin
            addrNxt = sp_r - 16'h0001;
            rdWrNxt = 1'b0;
            dataNxt = ret_r[15:8];
         end
         default: addrNxt = pc_r;
      endcase
   end

   //==========================================================
   // Registers
   //==========================================================
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= CBCS_IDLE;
         addr_r <= IDLE_ADDR;
         rdWr_r <= 1'b1;
         dataOut_r <= 8'h00;
         busy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         addr_r <= addrNxt;
         rdWr_r <= rdWrNxt;
         dataOut_r <= dataNxt;
         // Busy follows the next state, so it rises with the second bus cycle of a sequence, after the opcode read.
         busy_r <= (state_nxt != CBCS_IDLE);
      end
   end

   // Data captured from reads, and program counter and stack updates.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ofs_r <= 8'h00;
         vecHi_r <= 8'h00;
         ret_r <= 16'h0000;
         pc_r <= PC_RESET;
         sp_r <= SP_RESET;
      end else begin
         unique case (state_r)
            CBCS_BR_OFS, CBCS_SB_OFS: ofs_r <= dataIn;
            CBCS_SWI_VH: vecHi_r <= dataIn;
            // RULE2: program counter from vector
            CBCS_SWI_VL: pc_r <= {vecHi_r, dataIn};
            // RULE3: taken branch moves the counter
            CBCS_BR_DUM: pc_r <= takeBranch ? target : base;
            CBCS_SB_DUM: ret_r <= base;
            CBCS_SB_TGT: pc_r <= target;
            // RULE6: stack lowered by two
            CBCS_SB_WHI: sp_r <= sp_r - 16'h0002;
            default: ;
         endcase
         if (isIdle && start && op == CBCS_OP_SWI) ofs_r <= 8'h00;
      end
   end

   //==========================================================
   // Checks
   //==========================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // RULE1: flags write cycle
   a_swi_flags_write: assert property ( // RULE1
      state_r == CBCS_SWI_CC |-> !rdWr_r && addr_r == sp_r - FLAGS_OFS && dataOut_r == flags
   ) else $error("flags not written at SP-6");
   // RULE1: dummy read cycle
   a_swi_dummy_read: assert property ( // RULE1
      state_r == CBCS_SWI_CC |=> rdWr_r && addr_r == sp_r - DUMMY_OFS
   ) else $error("dummy read not at SP-7");
   // RULE2: vector fetch order
   a_vector_fetch: assert property ( // RULE2
      state_r == CBCS_SWI_DUM |=> addr_r == VEC_HI_ADDR ##1 addr_r == VEC_LO_ADDR
   ) else $error("vector fetch order wrong");
   // RULE2: vector loads counter
   a_vector_load: assert property ( // RULE2
      state_r == CBCS_SWI_VL |=> pc_r == {vecHi_r, $past(dataIn)}
   ) else $error("vector not loaded");
   // The first cycle after reset still shows the reset address, so it is left out here.
   // RULE3: opcode read cycle
   a_opcode_read: assert property ( // RULE3
      isIdle && start && op != CBCS_OP_NONE && $past(nrst) |-> rdWr_r && addr_r == pc_r
   ) else $error("opcode cycle not read at the program counter");
   // RULE3: three cycle branch
   a_branch_length: assert property ( // RULE3
      isIdle && start && op == CBCS_OP_BRANCH |=> busy_r ##1 (busy_r && addr_r == IDLE_ADDR)
      ##1 !busy_r
   ) else $error("branch not three cycles");
   // RULE3: untaken branch skips offset
   a_branch_pc: assert property ( // RULE3
      state_r == CBCS_BR_DUM && !takeBranch |=> pc_r == $past(pc_r) + 16'h0002
   ) else $error("untaken branch did not step past the offset");
   // RULE3: sequence needs start
   a_idle_quiet: assert property ( // RULE3
      isIdle && !(start && op != CBCS_OP_NONE) |=> !busy_r && rdWr_r
   ) else $error("sequence began without a request");
   // RULE4: target opcode fetch
   a_sub_target: assert property ( // RULE4
      state_r == CBCS_SB_DUM |=> addr_r == target && rdWr_r
   ) else $error("target fetch wrong");
   // RULE4: six cycle subroutine
   a_sub_length: assert property ( // RULE4
      isIdle && start && op == CBCS_OP_SUB |=> busy_r ##1 (busy_r && addr_r == IDLE_ADDR)
      ##1 busy_r ##1 busy_r ##1 busy_r ##1 !busy_r
   ) else $error("subroutine branch not six cycles");
   // RULE5: return address writes
   a_sub_writes: assert property ( // RULE5
      state_r == CBCS_SB_TGT |=> (!rdWr_r && addr_r == sp_r)
      ##1 (!rdWr_r && addr_r == sp_r - 16'h0001)
   ) else $error("return address writes wrong");
   // RULE5: return address bytes
   a_sub_write_data: assert property ( // RULE5
      state_r == CBCS_SB_TGT |=> dataOut_r == ret_r[7:0] ##1 dataOut_r == ret_r[15:8]
   ) else $error("return address bytes in wrong order");
   // RULE6: stack lowered by two
   a_sub_stack: assert property ( // RULE6
      state_r == CBCS_SB_WHI |=> sp_r == $past(sp_r) - 16'h0002
   ) else $error("stack not lowered by two");

   //==========================================================
   // Covers
   //==========================================================
   c_swi_seq: cover property (state_r == CBCS_SWI_VL);
   c_branch_taken: cover property (state_r == CBCS_BR_DUM && takeBranch);
   c_branch_not: cover property (state_r == CBCS_BR_DUM && !takeBranch);
   c_sub_seq: cover property (state_r == CBCS_SB_WHI);
   c_refused: cover property (busy_r && start);
endmodule // cbcs_sequencer

/* hw/cbcs_target_calc.sv */
// Branch target: base plus sign-extended 8-bit offset.
module cbcs_target_calc (
   input wire logic [15:0] base,
   input wire logic [7:0] offset,
   output logic [15:0] target
);
   assign target = base + {{8{offset[7]}}, offset};
endmodule // cbcs_target_calc

/* test/cbcs_mem_model.sv */
//==========================================================
// Memory on the processor bus
module cbcs_mem_model (
   input wire logic clk,
   input wire logic [15:0] addr_r,
   input wire logic rdWr_r,
   output logic [7:0] dataIn
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] lastRd_r = 8'h00;
   wire logic [7:0] rdByte = addr_r[7:0] ^ addr_r[15:8] ^ 8'h5a;
   // The bus is released during writes, so the inverse of the last byte shows a stray sample.
   assign dataIn = rdWr_r ? rdByte : ~lastRd_r;
   always_ff @(posedge clk) begin
      if (rdWr_r) begin
         lastRd_r <= rdByte;
      end
   end
endmodule // cbcs_mem_model

/* test/tb_top.sv */
//==========================================================
// Sequencer bench
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import cbcs_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic start = 1'b0;
   cbcs_op_t op = CBCS_OP_NONE;
   logic takeBranch = 1'b0;
   logic [7:0] flags = 8'h00;
   logic [7:0] dataIn, dataOut_r;
   logic [15:0] addr_r, pc_r, sp_r;
   logic rdWr_r, busy_r;
   int err_count = 0;
   int n_compared = 0;
   always #25 clk = ~clk;
   cbcs_sequencer uut (.clk(clk), .nrst(nrst), .start(start), .op(op), .takeBranch(takeBranch),
      .flags(flags), .dataIn(dataIn), .addr_r(addr_r), .rdWr_r(rdWr_r), .dataOut_r(dataOut_r),
      .pc_r(pc_r), .sp_r(sp_r), .busy_r(busy_r));
   cbcs_mem_model mem (.clk(clk), .addr_r(addr_r), .rdWr_r(rdWr_r), .dataIn(dataIn));

   function automatic logic [7:0] pat(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5a;
   endfunction

   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", what, e, g);
         err_count++;
      end
   endtask

   // One bus cycle is judged just after the edge that opens it.
   task automatic bus(input logic [15:0] a, input logic rw, input logic [7:0] d);
      #1;
      chk("addr", a, addr_r);
      chk("rdWr", {15'h0, rw}, {15'h0, rdWr_r});
      chk("dataOut", {8'h00, d}, {8'h00, dataOut_r});
      chk("busy", 16'h1, {15'h0, busy_r});
      @(posedge clk);
   endtask

   // The cycle in which start is raised is the opcode read at the program counter.
   task automatic kick(input cbcs_op_t o);
      logic [15:0] p;
      p = pc_r;
      @(posedge clk);
      start <= 1'b1;
      op <= o;
      #1;
      chk("opcode addr", p, addr_r);
      chk("opcode rdWr", 16'h1, {15'h0, rdWr_r});
      @(posedge clk);
      start <= 1'b0;
   endtask

   task automatic chk_rst;
      chk("rst addr", 16'hffff, addr_r);
      chk("rst rdWr", 16'h1, {15'h0, rdWr_r});
      chk("rst dataOut", 16'h0, {8'h00, dataOut_r});
      chk("rst pc", 16'h0, pc_r);
      chk("rst sp", 16'h0, sp_r);
      chk("rst busy", 16'h0, {15'h0, busy_r});
   endtask

   task automatic t_swi;
      logic [15:0] s;
      s = sp_r;
      flags <= 8'hc3;
      kick(CBCS_OP_SWI);
      bus(s - 16'h6, 1'b0, 8'hc3);
      bus(s - 16'h7, 1'b1, 8'h00);
      bus(16'hfffa, 1'b1, 8'h00);
      bus(16'hfffb, 1'b1, 8'h00);
      #1;
      chk("pc", {pat(16'hfffa), pat(16'hfffb)}, pc_r);
      chk("busy", 16'h0, {15'h0, busy_r});
      $display("test swi done");
   endtask

   task automatic t_branch(input logic tk);
      logic [15:0] p, tgt;
      logic [7:0] o;
      p = pc_r;
      o = pat(p + 16'h1);
      tgt = p + 16'h2 + (tk ? {{8{o[7]}}, o} : 16'h0);
      takeBranch <= tk;
      kick(CBCS_OP_BRANCH);
      bus(p + 16'h1, 1'b1, 8'h00);
      bus(16'hffff, 1'b1, 8'h00);
      #1;
      chk("pc", tgt, pc_r);
      chk("busy", 16'h0, {15'h0, busy_r});
      $display("test branch done");
   endtask

   task automatic t_sub;
      logic [15:0] p, s, tgt, ret;
      logic [7:0] o;
      p = pc_r;
      s = sp_r;
      o = pat(p + 16'h1);
      ret = p + 16'h2;
      tgt = ret + {{8{o[7]}}, o};
      kick(CBCS_OP_SUB);
      bus(p + 16'h1, 1'b1, 8'h00);
      bus(16'hffff, 1'b1, 8'h00);
      bus(tgt, 1'b1, 8'h00);
      bus(s, 1'b0, ret[7:0]);
      bus(s - 16'h1, 1'b0, ret[15:8]);
      #1;
      chk("pc", tgt, pc_r);
      chk("sp", s - 16'h2, sp_r);
      chk("busy", 16'h0, {15'h0, busy_r});
      $display("test subroutine done");
   endtask

   // A request with no operation, and one raised while busy, must both be ignored.
   task automatic t_refuse;
      logic [15:0] p;
      p = pc_r;
      takeBranch <= 1'b0;
      kick(CBCS_OP_NONE);
      #1;
      chk("busy", 16'h0, {15'h0, busy_r});
      chk("addr", p, addr_r);
      @(posedge clk);
      start <= 1'b1;
      op <= CBCS_OP_BRANCH;
      @(posedge clk);
      op <= CBCS_OP_SWI;
      bus(p + 16'h1, 1'b1, 8'h00);
      start <= 1'b0;
      bus(16'hffff, 1'b1, 8'h00);
      #1;
      chk("pc", p + 16'h2, pc_r);
      chk("busy", 16'h0, {15'h0, busy_r});
      $display("test refuse done");
   endtask

   // Reset in the middle of an interrupt tail must abandon it.
   task automatic t_reset;
      logic [15:0] s;
      s = sp_r;
      flags <= 8'h3c;
      kick(CBCS_OP_SWI);
      bus(s - 16'h6, 1'b0, 8'h3c);
      nrst <= 1'b0;
      #1;
      chk_rst;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      $display("test reset done");
   endtask

   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge clk);
      #1;
      chk_rst;
      @(posedge clk);
      nrst <= 1'b1;
      t_swi;
      t_branch(1'b0);
      t_branch(1'b1);
      t_branch(1'b1);
      t_sub;
      t_refuse;
      t_reset;
      t_branch(1'b1);
      results;
   end

   initial begin
      #20000;
      err_count++;
      $display("watchdog expired");
      results;
   end
endmodule // tb_top
